// File: rtl/spu_serial_port.sv
// four-mode serial port: shift register mode and three asynchronous frame modes
//
// Contract
// RULE1: mode 0 shifts 8 bits, txd carries clock
// RULE2: mode 0 write loads marker, send later
// RULE3: shift clock low S3-S5, shift at S6P2
// RULE4: marker pattern ends send, sets tx done
// RULE5: mode 0 receive loads 11111110 pattern
// RULE6: mode 0 receive samples S5P2, shifts S6P2
// RULE7: zero at left ends mode 0 receive
// RULE8: mode 1 frame: start, 8 data, stop
// RULE9: mode 1 write loads 1, waits rollover
// RULE10: start bit, then data enable, then shifts
// RULE11: mode 1 transmit ends at tenth rollover
// RULE12: falling edge resets counter, loads 1FF
// RULE13: majority vote of samples seven to nine
// RULE14: non-zero start bit returns to hunting
// RULE15: mode 1 keep frame only when allowed
// RULE16: modes 2/3 frame carries ninth bit
// RULE17: mode 2 fixed rate, mode 3 timer rate
// RULE18: baud_double halves mode 2 divisor
// RULE19: modes 2/3 transmit ninth bit, eleven rollovers
// RULE20: modes 2/3 receive like mode 1
// RULE21: modes 2/3 keep gate, hunt one bit later
// RULE22: separate transmit and receive buffers
// RULE23: asynchronous receive only with receive_enable
// RULE24: mode_select bits pick one of four modes
// RULE25: software clears both done flags
`timescale 1ns/1ps
module spu_serial_port (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // variable rate source for modes 1 and 3
    input  wire logic       timer_overflow,
    // serial pins
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd_out
);
    import spu_pkg::*;

    logic [7:0]    serial_control;
    logic [7:0]    aux_control;
    logic [7:0]    serial_buffer;
    logic [8:0]    tx_sreg;
    logic [8:0]    rx_sreg;
    logic [3:0]    phase;
    logic [1:0]    m2_pre;
    logic          ovf_half;
    logic          tx_roll_pend;
    logic          tx_shifted;
    logic          rx_first;
    logic          rx_last;
    logic          vote_a;
    logic          vote_b;
    logic          m0_sample;
    spu_tx_state_e tx_state;
    spu_rx_state_e rx_state;

    logic [7:0]    next_control;
    logic [8:0]    next_tx_sreg;
    logic [8:0]    next_rx_sreg;
    logic [3:0]    next_phase;
    logic          next_tx_shifted;
    logic          next_rx_first;
    logic          next_txd;
    logic          next_rxd;
    logic          next_rxd_oe;
    logic [7:0]    next_rdata;
    spu_tx_state_e next_tx_state;
    spu_rx_state_e next_rx_state;

    logic          tx_done_set;
    logic          rx_done_set;
    logic          rx_accept;
    logic          m0_load;

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == SPU_CTRL_ADDR);
    wire wr_buf  = reg_wr && (reg_addr == SPU_BUF_ADDR);
    wire wr_aux  = reg_wr && (reg_addr == SPU_AUX_ADDR);

    // control fields
    wire spu_mode_e mode  = spu_mode_e'(serial_control[SPU_MODE_HI_BIT:SPU_MODE_LO_BIT]); // RULE24
    wire is_m0            = (mode == SPU_MODE0);
    wire is_m1            = (mode == SPU_MODE1);
    wire is_m2            = (mode == SPU_MODE2);
    wire multiproc_enable = serial_control[SPU_MULTIPROC_BIT];
    wire receive_enable   = serial_control[SPU_RX_EN_BIT];
    wire tx_ninth_bit     = serial_control[SPU_TX_NINTH_BIT];
    wire rx_ninth_bit     = serial_control[SPU_RX_NINTH_BIT];
    wire tx_done_flag     = serial_control[SPU_TX_DONE_BIT];
    wire rx_done_flag     = serial_control[SPU_RX_DONE_BIT];
    wire baud_double      = aux_control[SPU_BAUD_DOUBLE_BIT];
    wire six_clk          = aux_control[SPU_SIX_CLK_BIT];

    // machine cycle: twelve phases, or six states of one clock in six-clock mode
    wire ph_end = (phase == SPU_PH_S6P2) || (six_clk && phase == SPU_PH_S6P1);
    wire s1p1   = (phase == SPU_PH_S1P1);
    wire s5p2   = (phase == SPU_PH_S5P2) || (six_clk && phase == SPU_PH_S5P2 - 4'h1);
    wire s6p2   = ph_end;
    wire s3_s5  = (phase >= SPU_PH_S3P1) && (phase <= SPU_PH_S5P2); // RULE3
    assign next_phase = ph_end ? SPU_PH_S1P1 : phase + (six_clk ? 4'h2 : 4'h1); // RULE1

    // 16x tick: fixed prescaler in mode 2, otherwise timer overflow, every second one unless baud_double or six_clk is set
    wire [1:0] m2_limit = six_clk ? (baud_double ? SPU_M2_PRE_FAST : SPU_M2_PRE_MID)
                                  : (baud_double ? SPU_M2_PRE_MID : SPU_M2_PRE_SLOW); // RULE18
    wire m2_hit  = (m2_pre == m2_limit);
    wire tick16  = is_m2 ? m2_hit
                         : (timer_overflow && (baud_double || six_clk || ovf_half)); // RULE17

    // pin synchroniser and bit-time counters
    logic       rx_pin;
    logic [3:0] rx_count;
    logic       tx_roll;
    logic       rx_edge;

    spu_sync u_rx_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_in    (rxd_in),
        .level_out (rx_pin)
    );

    spu_div16 #(.WIDTH(4)) u_tx_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (1'b0),
        .tick    (tick16),
        .count   (),
        .roll    (tx_roll)
    );

    // receive counter has its own copy so a start edge never disturbs transmit timing
    spu_div16 #(.WIDTH(4)) u_rx_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (rx_edge),
        .tick    (tick16),
        .count   (rx_count),
        .roll    ()
    );

    // asynchronous receive helpers
    assign rx_edge  = (rx_state == SPU_RX_IDLE) && !is_m0 && receive_enable
                      && tick16 && rx_last && !rx_pin; // RULE12 RULE23
    wire vote_tick  = tick16 && (rx_count == SPU_VOTE_LAST);
    wire vote       = (vote_a & vote_b) | (vote_a & rx_pin) | (vote_b & rx_pin); // RULE13
    wire rx_final   = (rx_state == SPU_RX_FRAME) && vote_tick && !rx_first && !rx_sreg[8];
    wire [7:0] m0_shifted = {rx_sreg[6:0], m0_sample};
    wire [7:0] asy_data   = {<<{rx_sreg[7:0]}};
    wire [7:0] m0_data    = {<<{m0_shifted}};

    // transmit sequencing
    wire tx_step  = s1p1 && tx_roll_pend; // RULE9
    wire tx_load  = wr_buf && (tx_state == SPU_TX_IDLE);
    wire tx_last  = (tx_sreg[8:1] == SPU_TX_END_PAT);
    wire send_m0  = (tx_state == SPU_TX_DATA) || (tx_state == SPU_TX_END);
    wire recv_m0  = (rx_state == SPU_RX_SHIFT) || (rx_state == SPU_RX_END);

    always_comb begin
        next_tx_state   = tx_state;
        next_tx_sreg    = tx_sreg;
        next_tx_shifted = tx_shifted;
        tx_done_set     = 1'b0;
        case (tx_state)
            SPU_TX_IDLE: begin
                if (wr_buf) begin
                    next_tx_sreg    = {(is_m0 || is_m1) ? 1'b1 : tx_ninth_bit, reg_wdata}; // RULE2 RULE9 RULE19
                    next_tx_shifted = 1'b0;
                    next_tx_state   = SPU_TX_WAIT;
                end
            end
            SPU_TX_WAIT: begin
                if (is_m0 ? s6p2 : tx_step) begin
                    next_tx_state = SPU_TX_START;
                end
            end
            SPU_TX_START: begin
                if (is_m0 ? s6p2 : tx_step) begin
                    next_tx_state = SPU_TX_DATA; // RULE2 RULE10
                end
            end
            SPU_TX_DATA: begin
                if (is_m0 && s6p2) begin
                    next_tx_sreg = {1'b0, tx_sreg[8:1]}; // RULE3
                    if (tx_last) begin
                        next_tx_state = SPU_TX_END; // RULE4
                    end
                end else if (!is_m0 && tx_step) begin
                    next_tx_sreg    = {!is_m1 && !tx_shifted, tx_sreg[8:1]}; // RULE10 RULE19
                    next_tx_shifted = 1'b1;
                    if (tx_last && tx_shifted) begin
                        next_tx_state = SPU_TX_IDLE; // RULE11 RULE19
                        tx_done_set   = 1'b1;
                    end
                end
            end
            SPU_TX_END: begin
                if (s1p1) begin
                    next_tx_state = SPU_TX_IDLE; // RULE4
                    tx_done_set   = 1'b1;
                end
            end
            default: begin
                next_tx_state = SPU_TX_IDLE;
            end
        endcase
    end

    // receive sequencing
    always_comb begin
        next_rx_state = rx_state;
        next_rx_sreg  = rx_sreg;
        next_rx_first = rx_first;
        rx_done_set   = 1'b0;
        rx_accept     = 1'b0;
        m0_load       = 1'b0;
        case (rx_state)
            SPU_RX_IDLE: begin
                if (is_m0 && receive_enable && !rx_done_flag && s1p1) begin
                    next_rx_state = SPU_RX_ARM; // RULE5 RULE25
                end else if (rx_edge) begin
                    next_rx_sreg  = SPU_ASY_RX_LOAD; // RULE12
                    next_rx_first = 1'b1;
                    next_rx_state = SPU_RX_FRAME;
                end
            end
            SPU_RX_ARM: begin
                if (s6p2) begin
                    next_rx_sreg  = {1'b0, SPU_M0_RX_LOAD}; // RULE5
                    next_rx_state = SPU_RX_SHIFT;
                end
            end
            SPU_RX_SHIFT: begin
                if (s6p2) begin
                    next_rx_sreg = {1'b0, m0_shifted}; // RULE6
                    if (!rx_sreg[7]) begin
                        m0_load       = 1'b1; // RULE7
                        next_rx_state = SPU_RX_END;
                    end
                end
            end
            SPU_RX_END: begin
                if (s1p1) begin
                    rx_done_set   = 1'b1; // RULE7
                    next_rx_state = SPU_RX_IDLE;
                end
            end
            SPU_RX_FRAME: begin
                if (vote_tick) begin
                    next_rx_first = 1'b0;
                    if (rx_first && vote) begin
                        next_rx_state = SPU_RX_IDLE; // RULE14
                    end else if (rx_final) begin
                        rx_accept     = !rx_done_flag && (!multiproc_enable || vote); // RULE15 RULE21
                        rx_done_set   = rx_accept;
                        next_rx_state = is_m1 ? SPU_RX_IDLE : SPU_RX_TAIL; // RULE20 RULE21
                    end else begin
                        next_rx_sreg = {rx_sreg[7:0], vote}; // RULE8 RULE16
                    end
                end
            end
            SPU_RX_TAIL: begin
                if (vote_tick) begin
                    next_rx_state = SPU_RX_IDLE; // RULE21
                end
            end
            default: begin
                next_rx_state = SPU_RX_IDLE;
            end
        endcase
    end

    // control register: hardware sets win over a software clear in the same cycle
    always_comb begin
        next_control = wr_ctrl ? reg_wdata : serial_control;
        if (rx_accept) begin
            next_control[SPU_RX_NINTH_BIT] = vote; // RULE8 RULE16
        end
        if (tx_done_set) begin
            next_control[SPU_TX_DONE_BIT] = 1'b1;
        end
        if (rx_done_set) begin
            next_control[SPU_RX_DONE_BIT] = 1'b1;
        end
    end

    // pin drive: txd is the shift clock in mode 0, frame data otherwise
    always_comb begin
        if (is_m0) begin
            next_txd    = (send_m0 || recv_m0) ? !s3_s5 : 1'b1; // RULE1 RULE3 RULE6
            next_rxd    = send_m0 ? tx_sreg[0] : 1'b1;
            next_rxd_oe = send_m0; // RULE1
        end else begin
            next_txd    = (tx_state == SPU_TX_START) ? 1'b0
                        : (tx_state == SPU_TX_DATA) ? tx_sreg[0] : 1'b1; // RULE10
            next_rxd    = 1'b1;
            next_rxd_oe = 1'b0;
        end
    end

    // read data: receive buffer is separate from the transmit register
    assign next_rdata = !reg_rd                      ? 8'h00
                      : (reg_addr == SPU_CTRL_ADDR) ? serial_control
                      : (reg_addr == SPU_BUF_ADDR)  ? serial_buffer // RULE22
                      : (reg_addr == SPU_AUX_ADDR)  ? aux_control : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_control <= SPU_CTRL_RESET;
            aux_control    <= SPU_AUX_RESET;
            serial_buffer  <= SPU_BUF_RESET;
            tx_state       <= SPU_TX_IDLE;
            rx_state       <= SPU_RX_IDLE;
            tx_sreg        <= '0;
            rx_sreg        <= '0;
            tx_shifted     <= 1'b0;
            rx_first       <= 1'b0;
            reg_rdata      <= 8'h00;
        end else begin
            serial_control <= next_control;
            aux_control    <= wr_aux ? reg_wdata : aux_control;
            tx_state       <= next_tx_state;
            rx_state       <= next_rx_state;
            tx_sreg        <= next_tx_sreg;
            rx_sreg        <= next_rx_sreg;
            tx_shifted     <= next_tx_shifted;
            rx_first       <= next_rx_first;
            reg_rdata      <= next_rdata;
            if (m0_load) begin
                serial_buffer <= m0_data; // RULE7
            end else if (rx_accept) begin
                serial_buffer <= asy_data; // RULE15 RULE20
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase        <= SPU_PH_S1P1;
            m2_pre       <= 2'h0;
            ovf_half     <= 1'b0;
            tx_roll_pend <= 1'b0;
            rx_last      <= 1'b1;
            vote_a       <= 1'b1;
            vote_b       <= 1'b1;
            m0_sample    <= 1'b1;
            txd_out      <= 1'b1;
            rxd_out      <= 1'b1;
            rxd_oe       <= 1'b0;
        end else begin
            phase        <= next_phase;
            m2_pre       <= m2_hit ? 2'h0 : m2_pre + 2'h1;
            ovf_half     <= ovf_half ^ timer_overflow;
            // the pending rollover is consumed at the following S1P1; one from before the write never starts a frame
            tx_roll_pend <= tx_roll || (tx_roll_pend && !s1p1 && !tx_load); // RULE9
            rx_last      <= tick16 ? rx_pin : rx_last;
            vote_a       <= (tick16 && rx_count == SPU_VOTE_FIRST) ? rx_pin : vote_a; // RULE13
            vote_b       <= (tick16 && rx_count == SPU_VOTE_MID) ? rx_pin : vote_b;
            m0_sample    <= s5p2 ? rx_pin : m0_sample; // RULE6
            txd_out      <= next_txd;
            rxd_out      <= next_rxd;
            rxd_oe       <= next_rxd_oe;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    tx_flag_cause_a: assert property ($rose(tx_done_flag) && !$past(wr_ctrl) |->
        $past(tx_state) inside {SPU_TX_DATA, SPU_TX_END}) // RULE4 RULE11
        else $error("tx done flag set outside end of transmission");
    m0_clock_low_a: assert property (is_m0 && send_m0 && s3_s5 && !wr_ctrl |=> !txd_out) // RULE3
        else $error("mode 0 shift clock not low in states three to five");
    start_bit_low_a: assert property (!is_m0 && tx_state == SPU_TX_START && !wr_ctrl |=> !txd_out) // RULE10
        else $error("start bit not driven low");
    false_start_a: assert property (rx_state == SPU_RX_FRAME && rx_first && vote_tick && vote |=>
        rx_state == SPU_RX_IDLE) // RULE14
        else $error("false start bit not rejected");
    edge_load_a: assert property (rx_edge |=> rx_sreg == SPU_ASY_RX_LOAD && rx_count == 4'h0) // RULE12
        else $error("start edge did not reset counter and load shift register");
    m0_rx_load_a: assert property (rx_state == SPU_RX_ARM && s6p2 |=>
        rx_sreg[7:0] == SPU_M0_RX_LOAD ##1 rx_state == SPU_RX_SHIFT) // RULE5
        else $error("mode 0 receive register not loaded");
    keep_gate_a: assert property (rx_final && (rx_done_flag || (multiproc_enable && !vote)) |=>
        $stable(serial_buffer)) // RULE15 RULE21
        else $error("frame kept although gate was closed");
    ninth_load_a: assert property (wr_buf && tx_state == SPU_TX_IDLE && !is_m0 && !is_m1 |=>
        tx_sreg[8] == $past(tx_ninth_bit)) // RULE19
        else $error("ninth transmit bit not loaded");
    m1_marker_a: assert property (wr_buf && tx_state == SPU_TX_IDLE && (is_m0 || is_m1) |=>
        tx_sreg[8] && tx_state == SPU_TX_WAIT) // RULE2 RULE9
        else $error("marker bit not loaded on write");

    m0_tx_done_c: cover property (is_m0 && tx_state == SPU_TX_END ##[1:12] tx_state == SPU_TX_IDLE);
    m0_rx_done_c: cover property (rx_state == SPU_RX_END ##[1:12] rx_done_flag);
    asy_accept_c: cover property (rx_accept && !is_m1);
    false_start_c: cover property (rx_state == SPU_RX_FRAME && rx_first && vote_tick && vote);

endmodule

// File: rtl/spu_pkg.sv
// constants, register map and state encodings for the four-mode serial port
package spu_pkg;

    // register addresses on the plain register port
    localparam logic [7:0] SPU_CTRL_ADDR   = 8'h98;
    localparam logic [7:0] SPU_BUF_ADDR    = 8'h99;
    localparam logic [7:0] SPU_AUX_ADDR    = 8'h9A;

    // values after reset
    localparam logic [7:0] SPU_CTRL_RESET  = 8'h00;
    localparam logic [7:0] SPU_AUX_RESET   = 8'h00;
    localparam logic [7:0] SPU_BUF_RESET   = 8'h00;

    // serial_control field positions
    localparam int SPU_MODE_HI_BIT   = 7;
    localparam int SPU_MODE_LO_BIT   = 6;
    localparam int SPU_MULTIPROC_BIT = 5;
    localparam int SPU_RX_EN_BIT     = 4;
    localparam int SPU_TX_NINTH_BIT  = 3;
    localparam int SPU_RX_NINTH_BIT  = 2;
    localparam int SPU_TX_DONE_BIT   = 1;
    localparam int SPU_RX_DONE_BIT   = 0;

    // auxiliary register field positions
    localparam int SPU_BAUD_DOUBLE_BIT = 7;
    localparam int SPU_SIX_CLK_BIT     = 0;

    typedef enum logic [1:0] {
        SPU_MODE0 = 2'h0,
        SPU_MODE1 = 2'h1,
        SPU_MODE2 = 2'h2,
        SPU_MODE3 = 2'h3
    } spu_mode_e;

    // machine cycle phases: index = 2*(state-1) + (phase-1)
    localparam logic [3:0] SPU_PH_S1P1 = 4'h0;
    localparam logic [3:0] SPU_PH_S3P1 = 4'h4;
    localparam logic [3:0] SPU_PH_S5P2 = 4'h9;
    localparam logic [3:0] SPU_PH_S6P1 = 4'hA;
    localparam logic [3:0] SPU_PH_S6P2 = 4'hB;

    // divide-by-16 counter states
    localparam logic [3:0] SPU_VOTE_FIRST = 4'h7;
    localparam logic [3:0] SPU_VOTE_MID   = 4'h8;
    localparam logic [3:0] SPU_VOTE_LAST  = 4'h9;

    // mode 2 prescaler limits, clocks per 16x tick minus one
    localparam logic [1:0] SPU_M2_PRE_SLOW = 2'h3;
    localparam logic [1:0] SPU_M2_PRE_MID  = 2'h1;
    localparam logic [1:0] SPU_M2_PRE_FAST = 2'h0;

    // shift register patterns
    localparam logic [7:0] SPU_M0_RX_LOAD  = 8'hFE;
    localparam logic [8:0] SPU_ASY_RX_LOAD = 9'h1FF;
    localparam logic [7:0] SPU_TX_END_PAT  = 8'h01;

    typedef enum logic [4:0] {
        SPU_TX_IDLE  = 5'h01,
        SPU_TX_WAIT  = 5'h02,
        SPU_TX_START = 5'h04,
        SPU_TX_DATA  = 5'h08,
        SPU_TX_END   = 5'h10
    } spu_tx_state_e;

    typedef enum logic [5:0] {
        SPU_RX_IDLE  = 6'h01,
        SPU_RX_ARM   = 6'h02,
        SPU_RX_SHIFT = 6'h04,
        SPU_RX_END   = 6'h08,
        SPU_RX_FRAME = 6'h10,
        SPU_RX_TAIL  = 6'h20
    } spu_rx_state_e;

endpackage

// File: rtl/spu_sync.sv
// two-stage synchroniser for a pin input
`timescale 1ns/1ps
module spu_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // pin and synchronised level
    input  wire logic pin_in,
    output logic      level_out
);
    logic stage_one;

    // idle serial line is high, so both stages start high
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage_one <= 1'b1;
            level_out <= 1'b1;
        end else begin
            stage_one <= pin_in;
            level_out <= stage_one;
        end
    end
endmodule

// File: rtl/spu_div16.sv
// divide-by-16 bit-time counter with synchronous clear
`timescale 1ns/1ps
module spu_div16 #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // control
    input  wire logic             clear,
    input  wire logic             tick,
    // state
    output logic [WIDTH-1:0]      count,
    output logic                  roll
);
    assign roll = tick & (&count);

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end
endmodule

// File: bench/spu_peer.sv
// far-side serial node: sends and takes asynchronous frames and mode 0 bytes
`timescale 1ns/1ps
module spu_peer (
    // clock and pins
    input  wire logic clk_sys,
    input  wire logic txd_out,
    input  wire logic rxd_out,
    output logic      line_out
);
    initial line_out = 1'b1;
    // start 0, n bits lsb first, stop 1; a very short bt makes a false start
    task automatic send(input logic [8:0] d, input int n, input int bt);
        for (int i = -1; i <= n; i++) begin
            @(posedge clk_sys);
            line_out <= (i < 0) ? 1'b0 : ((i == n) ? 1'b1 : d[i]);
            repeat (bt - 1) @(posedge clk_sys);
        end
    endtask
    // samples mid-bit after the start edge; d[n] ends up holding the stop bit
    task automatic recv(output logic [9:0] d, input int n, input int bt);
        d = '0;
        @(negedge txd_out);
        repeat (bt / 2) @(posedge clk_sys);
        for (int i = 0; i <= n; i++) begin
            repeat (bt) @(posedge clk_sys);
            d[i] = txd_out;
        end
    endtask
    // mode 0: data is taken on each rising shift clock
    task automatic recv0(output logic [9:0] d);
        d = '0;
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_out);
            d[i] = rxd_out;
        end
    endtask
    // next bit changes just after the rising shift clock, well clear of the sample point
    task automatic send0(input logic [7:0] d);
        @(posedge clk_sys);
        line_out <= d[0];
        for (int i = 1; i <= 8; i++) begin
            @(posedge txd_out);
            line_out <= (i == 8) ? 1'b1 : d[i];
        end
    endtask
endmodule

// File: bench/spu_serial_port_tb.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module spu_serial_port_tb;
    import spu_pkg::*;
    localparam logic [7:0] CTL = SPU_CTRL_ADDR;
    localparam logic [7:0] BUF = SPU_BUF_ADDR;
    localparam logic [7:0] AUX = SPU_AUX_ADDR;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, timer_overflow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic       rxd_out, rxd_oe, txd_out, peer_line;
    logic [9:0] frame;
    int         n_mismatch = 0, compares = 0, cyc = 0;
    // the device owns rxd while it sends in mode 0, the peer otherwise
    wire        rxd_line = rxd_oe ? rxd_out : peer_line;
    spu_serial_port u_spu_serial_port (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_overflow(timer_overflow), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .txd_out(txd_out));
    spu_peer u_spu_peer (.clk_sys(clk_sys), .txd_out(txd_out), .rxd_out(rxd_line), .line_out(peer_line));
    initial forever #50 clk_sys = ~clk_sys;
    // overflow every second clock keeps variable-rate frames short
    always @(posedge clk_sys) timer_overflow <= ~timer_overflow;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000)
            tally_and_finish(1);
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(10'(rv), 10'(exp));
    endtask
    task automatic poll(input int b, input logic [7:0] exp);
        rv = 8'h00;
        for (int i = 0; i < 200 && rv[b] !== 1'b1; i++)
            rd(CTL);
        chk(10'(rv), 10'(exp));
    endtask
    task automatic tally_and_finish(input int extra);
        n_mismatch += extra;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(CTL, SPU_CTRL_RESET);
        rdc(AUX, SPU_AUX_RESET);
        rdc(BUF, SPU_BUF_RESET);
        rdc(8'h55, 8'h00);
        $display("test reset done");
        wr(AUX, 8'h80);
        wr(CTL, 8'h88);
        fork
            wr(BUF, 8'hA5);
            u_spu_peer.recv(frame, 9, 32);
        join
        chk(frame, 10'h3A5);
        poll(1, 8'h8A);
        $display("test mode 2 transmit done");
        wr(AUX, 8'h00);
        wr(CTL, 8'h80);
        u_spu_peer.send(9'h1C3, 9, 64);
        rdc(CTL, 8'h80);
        wr(CTL, 8'h90);
        u_spu_peer.send(9'h1FF, 0, 4);
        repeat (100) @(posedge clk_sys);
        rdc(CTL, 8'h90);
        u_spu_peer.send(9'h13C, 9, 64);
        poll(0, 8'h95);
        rdc(BUF, 8'h3C);
        $display("test mode 2 receive done");
        wr(CTL, 8'hF0);
        u_spu_peer.send(9'h0C3, 9, 64);
        repeat (64) @(posedge clk_sys);
        rdc(CTL, 8'hF0);
        u_spu_peer.send(9'h1C3, 9, 64);
        poll(0, 8'hF5);
        rdc(BUF, 8'hC3);
        $display("test mode 3 address filter done");
        wr(AUX, 8'h80);
        wr(CTL, 8'h40);
        fork
            wr(BUF, 8'h5A);
            u_spu_peer.recv(frame, 8, 32);
        join
        chk(frame, 10'h15A);
        poll(1, 8'h42);
        wr(CTL, 8'h70);
        u_spu_peer.send(9'h1A6, 8, 32);
        poll(0, 8'h75);
        repeat (64) @(posedge clk_sys);
        u_spu_peer.send(9'h111, 8, 32);
        rdc(BUF, 8'hA6);
        $display("test mode 1 done");
        wr(CTL, 8'h00);
        fork
            wr(BUF, 8'hC9);
            u_spu_peer.recv0(frame);
        join
        chk(frame, 10'h0C9);
        poll(1, 8'h02);
        fork
            wr(CTL, 8'h10);
            u_spu_peer.send0(8'h6B);
        join
        poll(0, 8'h11);
        rdc(BUF, 8'h6B);
        $display("test mode 0 done");
        wr(CTL, 8'h00);
        wr(AUX, 8'h01);
        fork
            wr(BUF, 8'h3C);
            u_spu_peer.recv0(frame);
        join
        chk(frame, 10'h03C);
        poll(1, 8'h02);
        $display("test six-clock mode 0 done");
        tally_and_finish(0);
    end
endmodule
